// ---- rts_defs.vh ----
// Constants for the reset and time-out sequencer: timing, offsets, fields.
// Included by rts_top.v; holds definitions only.
`ifndef RTS_DEFS_VH
`define RTS_DEFS_VH

// System clock and internal slow tick
`define RTS_CLK_NS 25
`define RTS_TICK_NS 1000
`define RTS_TICK_CYC (`RTS_TICK_NS / `RTS_CLK_NS)

// Delays, in the unit their name carries
`define RTS_POWERUP_TIMER_US 17'h11940
`define RTS_PLL_US 17'h007d0
`define RTS_OST_CYC 1024
`define RTS_RECOV_NS 1500
`define RTS_RECOV_CYC ((`RTS_RECOV_NS + `RTS_CLK_NS - 1) / `RTS_CLK_NS)
`define RTS_BOR_QUAL_CYC 17'h00008

// APB register byte offsets
`define RTS_REG_RESET_CAUSE_CONTROL 12'h000
`define RTS_REG_STACK 12'h004
`define RTS_REG_CFG 12'h008
`define RTS_REG_STAT 12'h00c

// Reset cause control fields (flags are active low)
`define RTS_RC_INTERRUPT_PRIORITY_ENABLE 7
`define RTS_RC_RI 4
`define RTS_RC_TO 3
`define RTS_RC_PD 2
`define RTS_RC_POR 1
`define RTS_RC_BOR 0
`define RTS_RC_MASK 8'h9f
`define RTS_RESET_CAUSE_CONTROL_RST 8'h1c

// Stack status fields
`define RTS_STK_FULL 7
`define RTS_STK_UNF 6

// Configuration fields
`define RTS_CFG_MODE_LSB 0
`define RTS_CFG_PLL 3
`define RTS_CFG_POWERUP_TIMER 4
`define RTS_CFG_BROWNOUT_ENABLE_CFG 5
`define RTS_CFG_RST 8'h22

// Oscillator modes
`define RTS_MODE_LP 3'h0
`define RTS_MODE_XT 3'h1
`define RTS_MODE_HS 3'h2
`define RTS_MODE_EC 3'h3
`define RTS_MODE_RC 3'h4

// Program counter targets
`define RTS_PC_RESET 21'h000000
`define RTS_VEC_HIGH 21'h000008
`define RTS_VEC_LOW 21'h000018

`endif

// ---- rts_top.v ----
// Reset and time-out sequencer with reset-cause flags, reached over APB.
// Assumes detectors and pin are asynchronous; core events are on sys_clk.
//
// Notes on behaviour
// - Rising supply detection makes a power-on pulse that starts the sequence.
// - Power-up timer runs on the slow internal tick and holds reset.
// - Config bit 4 at 0 enables the power-up delay, 1 skips it.
// - After power-up delay, count 1024 main oscillator cycles.
// - Oscillator count only in crystal modes, after power-on, brown-out or wake.
// - With PLL enabled in HS mode, add a 2 ms lock delay after the count.
// - Brown-out enable bit: clear disables, set enables detection.
// - Qualified brown-out resets; reset held until supply recovers.
// - After brown-out rerun power-up timer; new brown-out restarts it.
// - Order is power-on pulse, power-up timer, oscillator count.
// - Delays run while the pin is low; release then starts at once.
// - RC mode: no delay, or only power-up delay when enabled.
// - External clock mode: short recovery on wake, and after power-on when the power-up delay is skipped.
// - Power-on and brown-out reset set their flag patterns, PC to zero.
// - Pin reset in normal run zeroes PC, flags unchanged.
// - Software reset clears only its own flag, PC to zero.
// - Stack resets set the matching stack flag, PC to zero.
// - Pin reset in sleep and watchdog reset set their flag patterns.
// - Wake resumes at PC+2 or the vector, flags per cause.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "rts_defs.vh"

module rts_top #(
  parameter [16:0] POWERUP_TIMER_TICKS = `RTS_POWERUP_TIMER_US,
  parameter [16:0] PLL_TICKS = `RTS_PLL_US,
  parameter [16:0] BOR_QUAL_CYC = `RTS_BOR_QUAL_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Asynchronous detectors, pin and oscillator
  input wire supply_rise_det,
  input wire brownout_det,
  input wire external_reset_pin_n,
  input wire main_osc,
  // Core events as one-cycle pulses on sys_clk; then wake priority, interrupt enables and current PC
  input wire sw_reset_req,
  input wire stack_full_evt,
  input wire stack_underflow_evt,
  input wire wdt_timeout_evt,
  input wire sleep_req,
  input wire irq_wake_evt,
  input wire irq_wake_high,
  input wire high_irq_global_enable,
  input wire low_irq_global_enable,
  input wire [20:0] pc_current,
  // Outputs to the core
  output reg reset_out,
  output reg core_stall,
  output reg pc_load,
  output reg [20:0] pc_value,
  output reg interrupt_priority_enable
);

  localparam [2:0] S_OFF = 3'h0;
  localparam [2:0] S_BOR = 3'h1;
  localparam [2:0] S_POWERUP_TIMER = 3'h2;
  localparam [2:0] S_OST = 3'h3;
  localparam [2:0] S_PLL = 3'h4;
  localparam [2:0] S_RECOV = 3'h5;
  localparam [2:0] S_RUN = 3'h6;
  localparam [2:0] S_SLEEP = 3'h7;
  localparam integer OST_LAST_I = `RTS_OST_CYC - 1;
  localparam integer RECOV_LAST_I = `RTS_RECOV_CYC - 1;
  localparam integer TICK_LAST_I = `RTS_TICK_CYC - 1;
  localparam [16:0] OST_LAST = OST_LAST_I[16:0];
  localparam [16:0] RECOV_LAST = RECOV_LAST_I[16:0];
  localparam [5:0] TICK_LAST = TICK_LAST_I[5:0];

  function is_xtal;
    input [2:0] mode;
    begin
      is_xtal = (mode == `RTS_MODE_LP) || (mode == `RTS_MODE_XT) ||
        (mode == `RTS_MODE_HS);
    end
  endfunction

  function [2:0] after_powerup_timer;
    input [2:0] mode;
    input powerup_timer_skip;
    begin
      if (is_xtal(mode))
        after_powerup_timer = S_OST;
      else if (mode == `RTS_MODE_EC && powerup_timer_skip)
        after_powerup_timer = S_RECOV;
      else
        after_powerup_timer = S_RUN;
    end
  endfunction

  // Synchronisers for supply, brown-out, pin and oscillator
  wire [3:0] async_in = {main_osc, external_reset_pin_n, brownout_det, supply_rise_det};
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk) begin
        if (rst) begin
          sync1_q[gi] <= (gi == 2) ? 1'b1 : 1'b0;
          sync2_q[gi] <= (gi == 2) ? 1'b1 : 1'b0;
        end else begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire supply_ok = sync2_q[0];
  wire bo_low = sync2_q[1];
  wire pin_n = sync2_q[2];
  wire osc_lvl = sync2_q[3];

  reg supply_prev_q;
  reg osc_prev_q;
  reg [5:0] tick_cnt_q;
  reg [16:0] bo_cnt_q;
  reg bor_act_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [16:0] cnt_q;
  reg [16:0] cnt_d;
  reg wake_q;
  reg wake_d;
  reg [20:0] wake_pc_q;
  reg [20:0] wake_pc_d;
  reg [7:0] reset_cause_control_q;
  reg [7:0] reset_cause_control_d;
  reg [7:0] stk_q;
  reg [7:0] stk_d;
  reg [7:0] cfg_q;
  reg pc_load_d;
  reg [20:0] pc_value_d;
  reg reset_out_d;

  wire por_pulse = supply_ok & ~supply_prev_q;
  wire osc_edge = osc_lvl & ~osc_prev_q;
  wire rc_tick = (tick_cnt_q == TICK_LAST);
  wire [2:0] mode = cfg_q[`RTS_CFG_MODE_LSB +: 3];
  wire pll_en = cfg_q[`RTS_CFG_PLL] && (mode == `RTS_MODE_HS);
  wire powerup_timer_skip = cfg_q[`RTS_CFG_POWERUP_TIMER];
  wire bor_en = cfg_q[`RTS_CFG_BROWNOUT_ENABLE_CFG];
  wire running = (state_q == S_RUN);
  wire in_sleep = (state_q == S_SLEEP);
  wire pin_fall = ~pin_n;

  // Slow tick standing in for the internal RC oscillator
  always @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt_q <= 6'h00;
      supply_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      tick_cnt_q <= rc_tick ? 6'h00 : tick_cnt_q + 6'h01;
      supply_prev_q <= supply_ok;
      osc_prev_q <= osc_lvl;
    end
  end

  // Brown-out must stay low for the qualifying time before it counts
  always @(posedge sys_clk) begin
    if (rst) begin
      bo_cnt_q <= 17'h00000;
      bor_act_q <= 1'b0;
    end else if (!bor_en || !bo_low) begin
      bo_cnt_q <= 17'h00000;
      bor_act_q <= 1'b0;
    end else if (bo_cnt_q == BOR_QUAL_CYC) begin
      bor_act_q <= 1'b1;
    end else begin
      bo_cnt_q <= bo_cnt_q + 17'h00001;
    end
  end

  // Core resets that hit while the core runs
  wire core_rst = running &
    (sw_reset_req | stack_full_evt | stack_underflow_evt | wdt_timeout_evt);

  // Sequencer
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    wake_d = wake_q;
    wake_pc_d = wake_pc_q;
    case (state_q)
      S_OFF: begin
        if (por_pulse) begin
          state_d = S_POWERUP_TIMER;
          cnt_d = 17'h00000;
        end
      end
      S_BOR: begin
        if (!bor_act_q) begin
          state_d = S_POWERUP_TIMER;
          cnt_d = 17'h00000;
        end
      end
      S_POWERUP_TIMER: begin
        if (powerup_timer_skip) begin
          state_d = after_powerup_timer(mode, 1'b1);
          cnt_d = 17'h00000;
        end else if (rc_tick) begin
          if (cnt_q == POWERUP_TIMER_TICKS - 17'h00001) begin
            state_d = after_powerup_timer(mode, 1'b0);
            cnt_d = 17'h00000;
          end else begin
            cnt_d = cnt_q + 17'h00001;
          end
        end
      end
      S_OST: begin
        if (osc_edge) begin
          if (cnt_q == OST_LAST) begin
            state_d = pll_en ? S_PLL : S_RUN;
            cnt_d = 17'h00000;
          end else begin
            cnt_d = cnt_q + 17'h00001;
          end
        end
      end
      S_PLL: begin
        if (rc_tick) begin
          if (cnt_q == PLL_TICKS - 17'h00001) begin
            state_d = S_RUN;
            cnt_d = 17'h00000;
          end else begin
            cnt_d = cnt_q + 17'h00001;
          end
        end
      end
      S_RECOV: begin
        if (cnt_q == RECOV_LAST) begin
          state_d = S_RUN;
          cnt_d = 17'h00000;
        end else begin
          cnt_d = cnt_q + 17'h00001;
        end
      end
      S_RUN: begin
        wake_d = 1'b0;
        if (sleep_req && pin_n && !core_rst)
          state_d = S_SLEEP;
      end
      S_SLEEP: begin
        if (pin_fall || wdt_timeout_evt || irq_wake_evt) begin
          // Pin reset in sleep takes the wake path but keeps reset held
          wake_d = ~pin_fall;
          // A watchdog wake resumes in line even with interrupts enabled
          if (irq_wake_evt && !wdt_timeout_evt &&
              (high_irq_global_enable || low_irq_global_enable))
            wake_pc_d = irq_wake_high ? `RTS_VEC_HIGH : `RTS_VEC_LOW;
          else
            wake_pc_d = pc_current + 21'h000002;
          cnt_d = 17'h00000;
          if (is_xtal(mode))
            state_d = S_OST;
          else if (mode == `RTS_MODE_EC)
            state_d = S_RECOV;
          else
            state_d = S_RUN;
        end
      end
      default: begin
        state_d = S_OFF;
      end
    endcase
    // Brown-out preempts all but supply loss and reinitialises the timer
    if (bor_act_q) begin
      state_d = S_BOR;
      cnt_d = 17'h00000;
      wake_d = 1'b0;
    end
    if (!supply_ok) begin
      state_d = S_OFF;
      cnt_d = 17'h00000;
      wake_d = 1'b0;
    end
  end

  // Reset output: any source, or any delay of a reset sequence
  always @* begin
    reset_out_d = 1'b0;
    if (state_d == S_OFF || state_d == S_BOR)
      reset_out_d = 1'b1;
    if (state_d != S_RUN && state_d != S_SLEEP && !wake_d)
      reset_out_d = 1'b1;
    if (!pin_n || core_rst)
      reset_out_d = 1'b1;
  end

  // Program counter load when reset or wake ends
  always @* begin
    pc_load_d = 1'b0;
    pc_value_d = pc_value;
    if (reset_out && !reset_out_d) begin
      pc_load_d = 1'b1;
      pc_value_d = `RTS_PC_RESET;
    end else if (wake_q && state_q != S_RUN && state_d == S_RUN) begin
      pc_load_d = 1'b1;
      pc_value_d = wake_pc_q;
    end else if (in_sleep && state_d == S_RUN && wake_d) begin
      pc_load_d = 1'b1;
      pc_value_d = wake_pc_d;
    end
  end

  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_done = psel & penable & pready;
  wire addr_ok = (paddr == `RTS_REG_RESET_CAUSE_CONTROL) || (paddr == `RTS_REG_STACK) ||
    (paddr == `RTS_REG_CFG) || (paddr == `RTS_REG_STAT);
  wire wr_reset_cause_control = apb_done & pwrite & (paddr == `RTS_REG_RESET_CAUSE_CONTROL);
  wire wr_stk = apb_done & pwrite & (paddr == `RTS_REG_STACK);
  wire wr_cfg = apb_done & pwrite & (paddr == `RTS_REG_CFG);

  reg [7:0] rd_byte;
  always @* begin
    case (paddr)
      `RTS_REG_RESET_CAUSE_CONTROL: rd_byte = reset_cause_control_q;
      `RTS_REG_STACK: rd_byte = stk_q;
      `RTS_REG_CFG: rd_byte = cfg_q & 8'h3f;
      `RTS_REG_STAT: rd_byte = {2'h0, bor_act_q, wake_q, reset_out, state_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // Flags: software write first, hardware events then override it
  always @* begin
    reset_cause_control_d = reset_cause_control_q;
    stk_d = stk_q;
    if (wr_reset_cause_control)
      reset_cause_control_d = pwdata[7:0] & `RTS_RC_MASK;
    if (wr_stk)
      stk_d = pwdata[7:0] & 8'hc0;
    if (state_q == S_OFF && por_pulse) begin
      reset_cause_control_d[`RTS_RC_RI] = 1'b1;
      reset_cause_control_d[`RTS_RC_TO] = 1'b1;
      reset_cause_control_d[`RTS_RC_PD] = 1'b1;
      reset_cause_control_d[`RTS_RC_POR] = 1'b0;
      reset_cause_control_d[`RTS_RC_BOR] = 1'b0;
      reset_cause_control_d[`RTS_RC_INTERRUPT_PRIORITY_ENABLE] = 1'b0;
    end
    if (bor_act_q && state_q != S_BOR) begin
      reset_cause_control_d[`RTS_RC_RI] = 1'b1;
      reset_cause_control_d[`RTS_RC_TO] = 1'b1;
      reset_cause_control_d[`RTS_RC_PD] = 1'b1;
      reset_cause_control_d[`RTS_RC_POR] = 1'b1;
      reset_cause_control_d[`RTS_RC_BOR] = 1'b0;
      reset_cause_control_d[`RTS_RC_INTERRUPT_PRIORITY_ENABLE] = 1'b0;
    end
    if (running && sw_reset_req) begin
      reset_cause_control_d[`RTS_RC_RI] = 1'b0;
      reset_cause_control_d[`RTS_RC_INTERRUPT_PRIORITY_ENABLE] = 1'b0;
    end
    if (running && stack_full_evt)
      stk_d[`RTS_STK_FULL] = 1'b1;
    if (running && stack_underflow_evt)
      stk_d[`RTS_STK_UNF] = 1'b1;
    if ((running && (stack_full_evt || stack_underflow_evt)) ||
        (running && !pin_n))
      reset_cause_control_d[`RTS_RC_INTERRUPT_PRIORITY_ENABLE] = 1'b0;
    if (running && wdt_timeout_evt) begin
      reset_cause_control_d[`RTS_RC_RI] = 1'b1;
      reset_cause_control_d[`RTS_RC_TO] = 1'b0;
      reset_cause_control_d[`RTS_RC_PD] = 1'b1;
      reset_cause_control_d[`RTS_RC_INTERRUPT_PRIORITY_ENABLE] = 1'b0;
    end
    if (in_sleep && pin_fall) begin
      reset_cause_control_d[`RTS_RC_TO] = 1'b1;
      reset_cause_control_d[`RTS_RC_PD] = 1'b0;
      reset_cause_control_d[`RTS_RC_INTERRUPT_PRIORITY_ENABLE] = 1'b0;
    end else if (in_sleep && wdt_timeout_evt) begin
      reset_cause_control_d[`RTS_RC_TO] = 1'b0;
      reset_cause_control_d[`RTS_RC_PD] = 1'b0;
    end else if (in_sleep && irq_wake_evt) begin
      reset_cause_control_d[`RTS_RC_TO] = 1'b1;
      reset_cause_control_d[`RTS_RC_PD] = 1'b0;
    end
  end

  // Registers
  always @(posedge sys_clk) begin
    if (rst) begin
      state_q <= S_OFF;
      cnt_q <= 17'h00000;
      wake_q <= 1'b0;
      wake_pc_q <= `RTS_PC_RESET;
      reset_cause_control_q <= `RTS_RESET_CAUSE_CONTROL_RST;
      stk_q <= 8'h00;
      cfg_q <= `RTS_CFG_RST;
      reset_out <= 1'b1;
      core_stall <= 1'b1;
      pc_load <= 1'b0;
      pc_value <= `RTS_PC_RESET;
      interrupt_priority_enable <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wake_q <= wake_d;
      wake_pc_q <= wake_pc_d;
      reset_cause_control_q <= reset_cause_control_d;
      stk_q <= stk_d;
      if (wr_cfg)
        cfg_q <= pwdata[7:0] & 8'h3f;
      reset_out <= reset_out_d;
      core_stall <= reset_out_d | (state_d != S_RUN);
      pc_load <= pc_load_d;
      pc_value <= pc_value_d;
      interrupt_priority_enable <= reset_cause_control_d[`RTS_RC_INTERRUPT_PRIORITY_ENABLE];
      // One wait state: ready in the second access cycle
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (apb_setup)
        prdata <= {24'h000000, rd_byte};
    end
  end

endmodule // rts_top

// ---- rts_far_model.sv ----
// Far side of the sequencer: supply detectors, reset pin, main crystal.
// Assumes the bench sets the control levels; the crystal runs free.
`timescale 1ns/1ps
module rts_far_model (
  // Levels chosen by the bench
  input wire pwr_on,
  input wire sag,
  input wire pin_hold,
  // Lines into the sequencer
  output wire supply_rise_det,
  output wire brownout_det,
  output wire external_reset_pin_n,
  output logic main_osc
);
  // Eight sys_clk periods a cycle gives each half exactly four
  initial main_osc = 1'b0;
  always #100 main_osc = ~main_osc;
  assign supply_rise_det = pwr_on;
  assign brownout_det = sag;
  // Pin has a pull-up, so only the hold switch pulls it low
  assign external_reset_pin_n = !pin_hold;
endmodule // rts_far_model

// ---- rts_chk.sv ----
// Checker on the sequencer's ports: APB timing, reset hold, PC loads.
// Assumes one sys_clk domain with a synchronous active-high rst.
`timescale 1ns/1ps
module rts_chk (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // APB handshake
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // Pin and core events
  input wire external_reset_pin_n,
  input wire sw_reset_req,
  input wire stack_full_evt,
  input wire stack_underflow_evt,
  input wire wdt_timeout_evt,
  input wire sleep_req,
  // Outputs to the core
  input wire reset_out,
  input wire core_stall,
  input wire pc_load,
  input wire [20:0] pc_value
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire any_evt = sw_reset_req | stack_full_evt | stack_underflow_evt | wdt_timeout_evt;
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  property p_apb_wait; s_setup |=> s_answer; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer late or early");
  property p_err_pair; pslverr |-> pready && psel && penable; endproperty
  a_err_pair: assert property (p_err_pair) else $error("error flag off completion");
  property p_pin_hold; !external_reset_pin_n [*6] |-> reset_out; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin low without reset");
  property p_stall; reset_out |-> core_stall; endproperty
  a_stall: assert property (p_stall) else $error("core runs in reset");
  property p_pc_zero; $fell(reset_out) |-> pc_load && pc_value == 21'h0; endproperty
  a_pc_zero: assert property (p_pc_zero) else $error("reset exit not at zero");
  property p_pc_pulse; pc_load |=> !pc_load; endproperty
  a_pc_pulse: assert property (p_pc_pulse) else $error("pc load longer than a cycle");
  property p_sw_reset; sw_reset_req && !core_stall |=> reset_out; endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset missed");
  property p_sleep;
    sleep_req && !core_stall && !any_evt |=> core_stall && !reset_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
endmodule // rts_chk

// ---- reset_timeout_sequencer_test.sv ----
// Bench: power-up delays per mode, reset events, sleep and brown-out.
// Assumes rts_top with short timer parameters and the far-side model.
`timescale 1ns/1ps
`include "rts_defs.vh"
module reset_timeout_sequencer_test;
  localparam int TK = 40;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, supply_rise_det, brownout_det, external_reset_pin_n, main_osc;
  logic pwr_on = 0, sag = 0, pin_hold = 0, sleep_req = 0, irq_wake_evt = 0, irq_wake_high = 0;
  logic high_irq_global_enable = 0, low_irq_global_enable = 0;
  logic [3:0] ev = '0;
  logic [20:0] pc_current = '0, pc_value;
  logic reset_out, core_stall, pc_load, interrupt_priority_enable;
  int n_mismatch = 0, compares = 0;
  logic [7:0] cfgs [8] = '{8'h22, 8'h32, 8'h3a, 8'h30, 8'h31, 8'h33, 8'h34, 8'h24};
  logic [7:0] erc [4] = '{8'h0f, 8'h0f, 8'h0f, 8'h17};
  logic [7:0] estk [4] = '{8'h00, 8'h80, 8'hc0, 8'hc0};
  always #12.5 sys_clk = ~sys_clk;
  rts_far_model i_far (.pwr_on, .sag, .pin_hold, .supply_rise_det, .brownout_det,
    .external_reset_pin_n, .main_osc);
  rts_top #(.POWERUP_TIMER_TICKS(17'd20), .PLL_TICKS(17'd5)) i_dut (.sys_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_rise_det, .brownout_det,
    .external_reset_pin_n, .main_osc, .sw_reset_req(ev[0]), .stack_full_evt(ev[1]),
    .stack_underflow_evt(ev[2]), .wdt_timeout_evt(ev[3]), .sleep_req, .irq_wake_evt,
    .irq_wake_high, .high_irq_global_enable, .low_irq_global_enable, .pc_current,
    .reset_out, .core_stall, .pc_load, .pc_value, .interrupt_priority_enable);
  function automatic int exp_t(logic [7:0] c);
    int t;
    t = c[4] ? 0 : 20 * TK;
    if (c[2:0] < 3) t += 1024 * 8 + ((c[3] && c[2:0] == 2) ? 5 * TK : 0);
    if (c[2:0] == 3 && c[4]) t += 60;
    return t;
  endfunction
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  // Slow tick and crystal phase are free, so a delay is allowed two ticks of slack
  task automatic tim(int e, int g);
    compares++;
    if (g < e - 2 * TK || g > e + 2 * TK + 20) begin
      n_mismatch++;
      $display("unexpected delay exp %0d got %0d", e, g);
    end
  endtask
  task automatic apb(bit w, logic [11:0] a, logic [31:0] d = 0);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic run_wait(output int t);
    t = 0;
    while ((reset_out !== 1'b0 || core_stall !== 1'b0) && t < 20000) begin
      @(posedge sys_clk);
      t++;
    end
    if (t >= 20000)
      chk("run", 0, 1);
  endtask
  task automatic sag_for(int n);
    sag <= 1;
    repeat (n) @(posedge sys_clk);
    sag <= 0;
  endtask
  task automatic pwrup(logic [7:0] c, bit p);
    int t;
    rst <= 1;
    pwr_on <= 0;
    pin_hold <= p;
    repeat (4) @(posedge sys_clk);
    rst <= 0;
    apb(1, `RTS_REG_CFG, c);
    pwr_on <= 1;
    if (p) begin
      repeat (exp_t(c) + 300) @(posedge sys_clk);
      chk("held", 1, reset_out);
      pin_hold <= 0;
    end
    run_wait(t);
    tim(p ? 0 : exp_t(c), t);
    apb(0, `RTS_REG_RESET_CAUSE_CONTROL);
    chk("reset_cause_control", 8'h1c, rd);
  endtask
  // k picks the wake cause: 0 interrupt, 1 watchdog, 2 reset pin
  task automatic nap(bit g, int k, int e, logic [7:0] er);
    logic [20:0] pc, e_pc;
    logic [1:0] gie;
    int t;
    pc = 21'($urandom) & 21'h1ffffe;
    gie = g ? 2'($urandom_range(3, 1)) : 2'b00;
    pc_current <= pc;
    {high_irq_global_enable, low_irq_global_enable} <= gie;
    irq_wake_high <= 1'($urandom);
    sleep_req <= 1;
    @(posedge sys_clk);
    sleep_req <= 0;
    repeat (4) @(posedge sys_clk);
    chk("stall", 1, core_stall);
    chk("asleep", 0, reset_out);
    if (k == 2)
      pin_hold <= 1;
    else if (k == 1)
      ev[3] <= 1;
    else
      irq_wake_evt <= 1;
    @(posedge sys_clk);
    irq_wake_evt <= 0;
    ev <= '0;
    if (k == 2) begin
      repeat (10) @(posedge sys_clk);
      pin_hold <= 0;
    end
    t = 0;
    while (pc_load !== 1'b1 && t < 20000) begin
      @(posedge sys_clk);
      t++;
    end
    chk("wake", 1, pc_load);
    tim(e, t);
    e_pc = pc + 21'd2;
    if (k == 2)
      e_pc = `RTS_PC_RESET;
    else if (k == 0 && g)
      e_pc = irq_wake_high ? `RTS_VEC_HIGH : `RTS_VEC_LOW;
    chk("pc", e_pc, pc_value);
    apb(0, `RTS_REG_RESET_CAUSE_CONTROL);
    chk("reset_cause_control", er, rd);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(100000 * 25);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    int t;
    void'($urandom(46));
    repeat (4) @(posedge sys_clk);
    rst <= 0;
    apb(0, `RTS_REG_CFG);
    chk("cfg", 8'h22, rd);
    apb(1, 12'h010, $urandom);
    chk("err", 1, err);
    apb(0, 12'h010);
    chk("unmapped", 0, rd);
    pwrup(8'h33, 1);
    foreach (cfgs[i]) pwrup(cfgs[i], 0);
    apb(0, `RTS_REG_STAT);
    chk("stat", 8'h06, rd);
    apb(1, `RTS_REG_RESET_CAUSE_CONTROL, 8'h9f);
    @(posedge sys_clk);
    chk("interrupt_priority_enable", 1, interrupt_priority_enable);
    foreach (erc[i]) begin
      ev[i] <= 1;
      @(posedge sys_clk);
      ev <= '0;
      repeat (3) @(posedge sys_clk);
      run_wait(t);
      apb(0, `RTS_REG_RESET_CAUSE_CONTROL);
      chk("reset_cause_control", erc[i], rd);
      apb(0, `RTS_REG_STACK);
      chk("stack", estk[i], rd);
    end
    chk("interrupt_priority_enable", 0, interrupt_priority_enable);
    pin_hold <= 1;
    repeat (10) @(posedge sys_clk);
    pin_hold <= 0;
    run_wait(t);
    apb(0, `RTS_REG_RESET_CAUSE_CONTROL);
    chk("reset_cause_control", 8'h17, rd);
    nap(0, 0, 0, 8'h1b);
    nap(1, 0, 0, 8'h1b);
    apb(1, `RTS_REG_CFG, 8'h31);
    nap(1, 1, 1024 * 8, 8'h13);
    apb(1, `RTS_REG_CFG, 8'h33);
    nap(0, 2, 50, 8'h1b);
    nap(1, 0, 60, 8'h1b);
    apb(1, `RTS_REG_CFG, 8'h24);
    sag_for(4);
    repeat (10) @(posedge sys_clk);
    chk("short sag", 0, reset_out);
    sag_for(30);
    chk("sag", 1, reset_out);
    repeat (400) @(posedge sys_clk);
    sag_for(30);
    run_wait(t);
    tim(20 * TK, t);
    apb(0, `RTS_REG_RESET_CAUSE_CONTROL);
    chk("reset_cause_control", 8'h1e, rd);
    apb(1, `RTS_REG_CFG, 8'h04);
    sag_for(30);
    repeat (10) @(posedge sys_clk);
    chk("sag off", 0, reset_out);
    tally_and_finish();
  end
endmodule // reset_timeout_sequencer_test
bind rts_top rts_chk i_chk (.sys_clk, .rst, .psel, .penable, .pready, .pslverr,
  .external_reset_pin_n, .sw_reset_req, .stack_full_evt, .stack_underflow_evt,
  .wdt_timeout_evt, .sleep_req, .reset_out, .core_stall, .pc_load, .pc_value);
